// *** logic/lrt_gap_timer.sv ***
// Rejection gap timer for L1 entry requests with its APB register.
//
// Local design decision: the APB slave port.
`default_nettype none
// Function
// - The port keeps a programmable 14-bit minimum gap (reset 0x947) between recognised L1 entry requests.
// - An entry request is a run of request DLLPs ended by the port's ack or nak.
// - Each gap unit is one clk_sys cycle of 5 ns at 200 MHz, so the wait is count times 5 ns.
// - After a rejection the port counts the gap before recognising a new request.
// - The gap timer starts when the nak has been sent, whatever the select bit.
// - A read-write select bit at position 16, reset 1, picks how early DLLPs act.
// - With select at 0 each early request DLLP restarts the timer from full count.
// - With select at 1 early request DLLPs are dropped and the timer runs on.
// - With select at 1 the first DLLP after expiry starts a fresh request.
module lrt_gap_timer
   import lrt_pkg::*;
#(
   parameter int GAP_WIDTH = LRT_GAP_WIDTH
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // APB slave
   input wire lrt_apb_req_type apb_req,
   output lrt_apb_rsp_type apb_rsp,
   // Power-management events from the link layer
   input wire lrt_pm_evt_type pm_evt,
   // Recognised requests and timer state
   output logic req_start,
   output logic req_accept,
   output logic timer_busy
);
   initial begin
      if (GAP_WIDTH != LRT_GAP_WIDTH) begin
         $error("lrt_gap_timer: GAP_WIDTH must match the register field");
      end
      if (LRT_GAP_LSB + LRT_GAP_WIDTH > LRT_SEL_BIT) begin
         $error("lrt_gap_timer: gap field overlaps the select bit");
      end
      if (LRT_SEL_BIT > 31) begin
         $error("lrt_gap_timer: select bit outside the data word");
      end
      if (LRT_UNIT_CYC < 1) begin
         $error("lrt_gap_timer: gap unit shorter than one clock");
      end
   end

   logic [GAP_WIDTH-1:0] gap_reg;
   logic sel_reg;
   logic [GAP_WIDTH-1:0] cnt_reg;
   logic busy_reg;
   logic in_req_reg;
   logic start_reg;
   logic accept_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic unit_tick;
   logic restart;
   logic early_dllp;
   logic idle_dllp;
   logic wr_hit;
   logic rd_hit;
   logic expire;

   function automatic logic [31:0] ctrl_word(logic [GAP_WIDTH-1:0] gap,
                                             logic sel);
      logic [31:0] w;
      w = 32'h00000000;
      w[LRT_GAP_LSB +: LRT_GAP_WIDTH] = gap;
      w[LRT_SEL_BIT] = sel;
      return w;
   endfunction

   // The slave takes an access in the one access cycle in which pready is still low.
   function automatic logic apb_take(lrt_apb_req_type req, logic rdy);
      return req.psel && req.penable && !rdy;
   endfunction

   // Only the control word is mapped; every other offset is a hole.
   function automatic logic ctrl_hit(logic [11:0] addr);
      return addr == LRT_CTRL_OFFSET;
   endfunction

   // Two-cycle access phase: pready rises in the second access cycle.
   assign wr_hit = apb_take(apb_req, pready_reg) && apb_req.pwrite &&
                   ctrl_hit(apb_req.paddr);
   assign rd_hit = apb_take(apb_req, pready_reg) && !apb_req.pwrite &&
                   ctrl_hit(apb_req.paddr);

   // A new gap value waits for the next restart, it never cuts a running count.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gap_reg <= LRT_GAP_RESET;
      end else if (wr_hit) begin
         gap_reg <= apb_req.pwdata[LRT_GAP_LSB +: LRT_GAP_WIDTH];
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sel_reg <= LRT_SEL_RESET;
      end else if (wr_hit) begin
         sel_reg <= apb_req.pwdata[LRT_SEL_BIT];
      end
   end

   // One pready pulse per take; an access still held once pready has fallen is taken again.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= apb_take(apb_req, pready_reg);
      end
   end

   // No access is refused, so the error response stays low.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pslverr_reg <= 1'b0;
      end else begin
         pslverr_reg <= 1'b0;
      end
   end

   // Unmapped reads return zero and unmapped writes are dropped without error.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         prdata_reg <= 32'h00000000;
      end else begin
         if (rd_hit) begin
            prdata_reg <= ctrl_word(gap_reg, sel_reg);
         end else begin
            prdata_reg <= LRT_RD_UNMAPPED;
         end
      end
   end

   assign apb_rsp = '{prdata: prdata_reg, pready: pready_reg,
                      pslverr: pslverr_reg};

   // A DLLP that meets a running timer is early, one that meets an idle
   // timer is recognised.
   assign early_dllp = pm_evt.req_dllp && busy_reg;
   assign idle_dllp = pm_evt.req_dllp && !busy_reg;
   assign restart = pm_evt.nak_sent || (early_dllp && !sel_reg);

   lrt_unit_tick u_tick (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .restart(restart),
      .tick(unit_tick)
   );

   assign expire = busy_reg && unit_tick && cnt_reg <= 14'h0001;

   // A zero gap never raises busy, so requests then pass straight through.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy_reg <= 1'b0;
      end else if (restart) begin
         busy_reg <= gap_reg != '0;
      end else if (expire) begin
         busy_reg <= 1'b0;
      end
   end

   // Count in gap units; a restart reloads the full programmed value.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= '0;
      end else if (restart) begin
         cnt_reg <= gap_reg;
      end else if (expire) begin
         cnt_reg <= '0;
      end else if (busy_reg && unit_tick) begin
         cnt_reg <= cnt_reg - 14'h0001;
      end
   end

   // A request runs from its first accepted DLLP to the port's answer.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         in_req_reg <= 1'b0;
      end else if (pm_evt.nak_sent || pm_evt.ack_sent) begin
         in_req_reg <= 1'b0;
      end else if (idle_dllp) begin
         in_req_reg <= 1'b1;
      end
   end

   // Start marks only the first DLLP of a fresh request.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         start_reg <= 1'b0;
      end else begin
         start_reg <= idle_dllp && !in_req_reg;
      end
   end

   // Accept marks every DLLP that meets an idle timer.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         accept_reg <= 1'b0;
      end else begin
         accept_reg <= idle_dllp;
      end
   end

   assign req_start = start_reg;
   assign req_accept = accept_reg;
   assign timer_busy = busy_reg;
endmodule
`default_nettype wire

// *** logic/lrt_pkg.sv ***
// Package for the L1 entry request rejection gap timer.
`default_nettype none
package lrt_pkg;
   localparam logic [11:0] LRT_CTRL_OFFSET = 12'h710;
   localparam int LRT_GAP_LSB = 0;
   localparam int LRT_GAP_WIDTH = 14;
   localparam int LRT_SEL_BIT = 16;
   localparam logic [13:0] LRT_GAP_RESET = 14'h0947;
   localparam logic LRT_SEL_RESET = 1'h1;
   localparam int LRT_CLK_MHZ = 200;
   localparam int LRT_UNIT_NS = 4;
   // Cycles of clk_sys per 4 ns gap unit, at least one.
   localparam int LRT_UNIT_CYC_RAW = (LRT_UNIT_NS * LRT_CLK_MHZ) / 1000;
   localparam int LRT_UNIT_CYC = (LRT_UNIT_CYC_RAW < 1) ? 1 :
      LRT_UNIT_CYC_RAW;
   localparam logic [31:0] LRT_RD_UNMAPPED = 32'h00000000;

   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } lrt_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } lrt_apb_rsp_type;

   typedef struct packed {
      logic req_dllp;
      logic nak_sent;
      logic ack_sent;
   } lrt_pm_evt_type;
endpackage
`default_nettype wire

// *** logic/lrt_unit_tick.sv ***
// Divider that marks each gap unit of DIV clk_sys cycles as a one-cycle enable.
`default_nettype none
module lrt_unit_tick
   import lrt_pkg::*;
#(
   parameter int DIV = LRT_UNIT_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Control
   input wire logic restart,
   output logic tick
);
   initial begin
      if (DIV < 1 || DIV > 255) begin
         $error("lrt_unit_tick: DIV out of range");
      end
   end

   logic [7:0] cnt_reg;

   // Restart realigns the unit so a full count never comes up short.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 8'h00;
      end else if (restart || cnt_reg == 8'(DIV - 1)) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   assign tick = !restart && (cnt_reg == 8'(DIV - 1));
endmodule
`default_nettype wire

// *** tb/lrt_gap_timer_checker.sv ***
// Assertion checker for the L1 rejection gap timer.
`default_nettype none
module lrt_gap_timer_checker
   import lrt_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Ports watched
   input wire lrt_apb_req_type apb_req,
   input wire lrt_apb_rsp_type apb_rsp,
   input wire lrt_pm_evt_type pm_evt,
   input wire logic req_start,
   input wire logic req_accept,
   input wire logic timer_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [13:0] gap_q;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // The gap is tracked here so that the busy check knows a gap below two.
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         gap_q <= LRT_GAP_RESET;
      end else if (apb_req.psel && apb_req.penable && apb_req.pwrite &&
         apb_rsp.pready && apb_req.paddr == LRT_CTRL_OFFSET) begin
         gap_q <= apb_req.pwdata[13:0];
      end
   end
   sequence s_nak;
      pm_evt.nak_sent && gap_q > 14'h1;
   endsequence
   pready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held too long");
   no_slverr_a: assert property (!apb_rsp.pslverr)
      else $error("pslverr raised");
   rsvd_zero_a: assert property (apb_rsp.pready |->
      apb_rsp.prdata[15:14] == 2'h0 && apb_rsp.prdata[31:17] == 15'h0)
      else $error("reserved bits not zero");
   nak_busy_a: assert property (s_nak |=> timer_busy[*2])
      else $error("timer not running after nak");
   early_drop_a: assert property (pm_evt.req_dllp && timer_busy
      |=> !req_accept) else $error("early request passed");
   idle_pass_a: assert property (pm_evt.req_dllp && !timer_busy &&
      !pm_evt.nak_sent |=> req_accept) else $error("request lost");
   start_pass_a: assert property (req_start |-> req_accept)
      else $error("start without accept");
   reset_idle_a: assert property ($rose(resetn) |-> !timer_busy)
      else $error("busy after reset");
endmodule
`default_nettype wire

// *** tb/lrt_gap_timer_tb_top.sv ***
// Testbench for the L1 rejection gap timer.
`default_nettype none
module lrt_gap_timer_tb_top
   import lrt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys = 1'h0, resetn = 1'h0, nak = 1'h0, ack = 1'h0;
   logic start, acc, busy, dllp;
   logic [31:0] r;
   lrt_apb_req_type rq = '0;
   lrt_apb_rsp_type rsp;
   wire lrt_pm_evt_type evt = {dllp, nak, ack};
   int fails = 0, n_compared = 0, n_start = 0, n_acc = 0, n, g, s0, k, a0;
   always #2.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (start === 1'h1) n_start++;
   always @(posedge clk_sys) if (acc === 1'h1) n_acc++;
   lrt_gap_timer u_lrt_gap_timer (.clk_sys(clk_sys), .resetn(resetn),
      .apb_req(rq), .apb_rsp(rsp), .pm_evt(evt), .req_start(start),
      .req_accept(acc), .timer_busy(busy));
   lrt_link_partner u_lrt_link_partner (.clk_sys(clk_sys), .req_dllp(dllp));
   task automatic chk(input string s, input logic [31:0] v, e);
      n_compared++;
      if (v !== e) begin
         fails++;
         $display("[ERR] %s exp %h seen %h", s, e, v);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge clk_sys) rq <= '{a, 1'h1, 1'h0, w, d};
      @(posedge clk_sys) rq.penable <= 1'h1;
      do @(posedge clk_sys); while (rsp.pready !== 1'h1);
      r = rsp.prdata;
      rq <= '0;
   endtask
   task automatic nak_run(output int c);
      @(posedge clk_sys) nak <= 1'h1;
      @(posedge clk_sys) nak <= 1'h0;
      #1 c = 0;
      while (busy === 1'h1) begin
         c++;
         @(posedge clk_sys);
         #1;
      end
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #20000;
      fails++;
      close_out;
   end
   initial begin
      void'($urandom(32'hf978501a));
      repeat (20) @(posedge clk_sys);
      resetn <= 1'h1;
      @(posedge clk_sys);
      apb(1'h0, 12'h710, 32'h0);
      chk("ctrl reset", r, 32'h00010947);
      apb(1'h1, 12'h714, 32'hFFFFFFFF);
      apb(1'h0, 12'h714, 32'h0);
      chk("unmapped", r, 32'h0);
      k = 1 + $urandom % 3;
      u_lrt_link_partner.send(k);
      repeat (2) @(posedge clk_sys);
      chk("first start", n_start, 32'h1);
      chk("idle accepts", n_acc, 32'(k));
      $display("reset test done");
      g = 3 + $urandom % 8;
      apb(1'h1, 12'h710, 32'hFFFFC000 | g);
      apb(1'h0, 12'h710, 32'h0);
      chk("ctrl rw", r, 32'h00010000 | g);
      a0 = n_acc;
      fork
         nak_run(n);
         u_lrt_link_partner.send(2);
      join
      chk("gap sel1", 32'(n), 32'(g));
      chk("early dropped", n_acc, 32'(a0 + 1));
      s0 = n_start;
      u_lrt_link_partner.send(2);
      @(posedge clk_sys) ack <= 1'h1;
      @(posedge clk_sys) ack <= 1'h0;
      chk("fresh start", n_start, s0 + 1);
      $display("select one test done");
      apb(1'h1, 12'h710, 32'(g));
      fork
         nak_run(n);
         begin
            repeat (2) @(posedge clk_sys);
            u_lrt_link_partner.send(1);
         end
      join
      chk("gap sel0", 32'(n), 32'(g + 2));
      $display("select zero test done");
      close_out;
   end
endmodule
bind lrt_gap_timer lrt_gap_timer_checker u_lrt_gap_timer_checker (
   .clk_sys(clk_sys), .resetn(resetn), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .pm_evt(pm_evt), .req_start(req_start),
   .req_accept(req_accept), .timer_busy(timer_busy));
`default_nettype wire

// *** tb/lrt_link_partner.sv ***
// Link partner model that sends L1 request DLLPs.
`default_nettype none
module lrt_link_partner (
   input wire logic clk_sys,
   output logic req_dllp
);
   timeunit 1ns;
   timeprecision 100ps;
   initial req_dllp = 1'h0;
   task automatic send(input int n);
      repeat (n) begin
         @(posedge clk_sys) req_dllp <= 1'h1;
         @(posedge clk_sys) req_dllp <= 1'h0;
      end
   endtask
endmodule
`default_nettype wire
